/* rtl/spd_pkg.sv */
package spd_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] SPD_ADR_FULL_SCALE = 8'h00;
	localparam logic [7:0] SPD_ADR_LATCH = 8'h04;
	localparam logic [7:0] SPD_ADR_STATUS = 8'h08;
	localparam logic [7:0] SPD_ADR_TARGET = 8'h0c;
	localparam logic [7:0] SPD_ADR_CHOP = 8'h10;

	localparam logic [7:0] SPD_FULL_SCALE_RST = 8'hff;
	localparam logic [7:0] SPD_STORE_RST = 8'h00;
	localparam logic [15:0] SPD_CHOP_DIV_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Storage word layout
	// ----------------------------------------------------------------
	localparam int SPD_BIT_PHASE_A = 7;
	localparam int SPD_BIT_ENABLE_A = 6;
	localparam int SPD_BIT_PHASE_B = 5;
	localparam int SPD_BIT_ENABLE_B = 4;
	localparam int SPD_TRQ_MSB = 3;
	localparam int SPD_TRQ_LSB = 0;
	localparam int SPD_LATCH_CMD_BIT = 0;

	// Status word layout
	localparam int SPD_ST_STORE_LSB = 0;
	localparam int SPD_ST_STANDBY = 8;
	localparam int SPD_ST_SUPPLY = 9;
	localparam int SPD_ST_RUN = 10;
	localparam int SPD_ST_ACT_A = 11;
	localparam int SPD_ST_ACT_B = 12;

	// Target word layout
	localparam int SPD_TGT_A_LSB = 0;
	localparam int SPD_TGT_B_LSB = 8;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SPD_CLK_PERIOD_NS = 8;
	localparam int SPD_CHOP_PERIOD_NS = 10000;
	localparam int SPD_CHOP_CYCLES = SPD_CHOP_PERIOD_NS / SPD_CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Torque ratio table, percent of full scale, code 0 to 15
	// ----------------------------------------------------------------
	localparam logic [14:0] SPD_PCT_DIV = 15'h0064;
	localparam logic [6:0] SPD_PCT [16] = '{
		7'h00, 7'h05, 7'h0a, 7'h0f, 7'h19, 7'h1d, 7'h26, 7'h2b,
		7'h34, 7'h3c, 7'h43, 7'h4a, 7'h50, 7'h56, 7'h5e, 7'h64
	};

endpackage : spd_pkg

/* rtl/spd_chan_if.sv */
interface spd_chan_if;
	// Commands toward one bridge channel
	logic phase;
	logic enable;
	logic run;
	logic [7:0] full_scale;
	logic [6:0] ratio;
	// Registered bridge state back to the top
	logic pos;
	logic pos_oe;
	logic neg;
	logic neg_oe;
	logic active;
	logic [7:0] target;

	modport ctl (
		output phase, enable, run, full_scale, ratio,
		input pos, pos_oe, neg, neg_oe, active, target
	);
	modport drv (
		input phase, enable, run, full_scale, ratio,
		output pos, pos_oe, neg, neg_oe, active, target
	);
endinterface : spd_chan_if

/* rtl/spd_channel.sv */
module spd_channel (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Channel commands and state
	spd_chan_if.drv ch
);

	logic [14:0] prod;
	logic [7:0] scaled;
	logic on;

	assign on = ch.run & ch.enable; // RULE_02 RULE_04
	assign prod = 15'(ch.full_scale) * 15'(ch.ratio);
	assign scaled = 8'(prod / spd_pkg::SPD_PCT_DIV); // RULE_10

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ch.pos <= 1'b0;
			ch.neg <= 1'b0;
			ch.pos_oe <= 1'b0;
			ch.neg_oe <= 1'b0;
			ch.active <= 1'b0;
			ch.target <= 8'h00;
		end
		else
		begin
			// Positive current runs from the plus to the minus terminal
			ch.pos <= ch.phase; // RULE_01 RULE_03
			ch.neg <= ~ch.phase; // RULE_03
			ch.pos_oe <= on; // RULE_02
			ch.neg_oe <= on; // RULE_02
			ch.active <= on;
			ch.target <= on ? scaled : 8'h00; // RULE_10
		end
	end

endmodule : spd_channel

/* rtl/spd_top.sv */
// Functional notes
// (RULE_01) Positive current flows plus to minus terminal
// (RULE_02) Output-on low floats that whole channel
// (RULE_03) Polarity high drives plus high, minus low
// (RULE_04) Standby low stops oscillator and both channels
// (RULE_05) Torque code maps to sixteen percent ratios
// (RULE_06) Full step: both on, polarity pairs cycle
// (RULE_07) Half step: eight states, one channel off
// (RULE_08) No drive without motor supply present
// (RULE_09) Bits come from storage latched on strobe
// (RULE_10) Target equals full scale times shared ratio
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
module spd_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial front end
	input wire logic [7:0] shift_word_i,
	input wire logic latch_strobe_i,
	// Device control levels
	input wire logic standby_n_i,
	input wire logic motor_supply_ok_i,
	// Chopper oscillator
	output logic chopper_oscillator_run_o,
	output logic chopper_oscillator_tick_o,
	// Channel A bridge
	output logic out_a_pos_o,
	output logic out_a_pos_oe_o,
	output logic out_a_neg_o,
	output logic out_a_neg_oe_o,
	output logic [7:0] target_a_o,
	// Channel B bridge
	output logic out_b_pos_o,
	output logic out_b_pos_oe_o,
	output logic out_b_neg_o,
	output logic out_b_neg_oe_o,
	output logic [7:0] target_b_o
);

	// ----------------------------------------------------------------
	// Wishbone decode
	// ----------------------------------------------------------------
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic req;
	logic wr_go;
	logic hit_fs;
	logic hit_latch;
	logic hit_status;
	logic hit_target;
	logic hit_chop;
	logic [31:0] status_word;
	logic [31:0] target_word;

	assign req = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack
	assign wr_go = req & wb_we_i & ack_reg;
	assign hit_fs = wb_adr_i == spd_pkg::SPD_ADR_FULL_SCALE;
	assign hit_latch = wb_adr_i == spd_pkg::SPD_ADR_LATCH;
	assign hit_status = wb_adr_i == spd_pkg::SPD_ADR_STATUS;
	assign hit_target = wb_adr_i == spd_pkg::SPD_ADR_TARGET;
	assign hit_chop = wb_adr_i == spd_pkg::SPD_ADR_CHOP;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic [7:0] full_scale_reg;
	logic [15:0] chop_div_reg;
	logic [7:0] store_reg;
	logic strobe_prev_reg;
	logic latch_go;
	logic sw_latch;

	assign sw_latch = wr_go & hit_latch & wb_sel_i[0]
		& wb_dat_i[spd_pkg::SPD_LATCH_CMD_BIT];
	// A rising edge of the strobe or a latch-word write captures; a held strobe level does not
	assign latch_go = (latch_strobe_i & ~strobe_prev_reg) | sw_latch;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			full_scale_reg <= spd_pkg::SPD_FULL_SCALE_RST;
			chop_div_reg <= spd_pkg::SPD_CHOP_DIV_RST;
			store_reg <= spd_pkg::SPD_STORE_RST;
			strobe_prev_reg <= 1'b0;
		end
		else
		begin
			strobe_prev_reg <= latch_strobe_i;
			if (latch_go)
				store_reg <= shift_word_i; // RULE_09
			if (wr_go & hit_fs & wb_sel_i[0])
				full_scale_reg <= wb_dat_i[7:0];
			if (wr_go & hit_chop & wb_sel_i[0])
				chop_div_reg[7:0] <= wb_dat_i[7:0];
			if (wr_go & hit_chop & wb_sel_i[1])
				chop_div_reg[15:8] <= wb_dat_i[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Run gating and torque ratio
	// ----------------------------------------------------------------
	logic run;
	logic [3:0] trq_code;
	logic [6:0] ratio;

	// Logic levels alone never drive the bridge without motor supply
	assign run = standby_n_i & motor_supply_ok_i; // RULE_04 RULE_08
	assign trq_code = store_reg[spd_pkg::SPD_TRQ_MSB:spd_pkg::SPD_TRQ_LSB];
	assign ratio = spd_pkg::SPD_PCT[trq_code]; // RULE_05

	// ----------------------------------------------------------------
	// Chopper oscillator
	// ----------------------------------------------------------------
	logic [15:0] chop_cnt_reg;
	logic [15:0] chop_cnt_next;
	logic [15:0] chop_last;
	logic chop_tick_reg;
	logic chop_wrap;

	// Zero in the divider register selects the nominal chopping period
	assign chop_last = (chop_div_reg == 16'h0000)
		? 16'(spd_pkg::SPD_CHOP_CYCLES - 1) : chop_div_reg;
	assign chop_wrap = chop_cnt_reg >= chop_last;
	assign chop_cnt_next = chop_wrap ? 16'h0000 : chop_cnt_reg + 16'h0001;

	always_ff @(posedge clk_i)
	begin
		if (rst_i | ~run)
		begin
			// Standby holds the oscillator still
			chop_cnt_reg <= 16'h0000; // RULE_04
			chop_tick_reg <= 1'b0;
		end
		else
		begin
			chop_cnt_reg <= chop_cnt_next;
			chop_tick_reg <= chop_wrap;
		end
	end

	assign chopper_oscillator_run_o = run;
	assign chopper_oscillator_tick_o = chop_tick_reg;

	// ----------------------------------------------------------------
	// Bridge channels
	// ----------------------------------------------------------------
	spd_chan_if ch_a ();
	spd_chan_if ch_b ();

	// Each channel decodes its own pair, so any step sequence works
	assign ch_a.phase = store_reg[spd_pkg::SPD_BIT_PHASE_A]; // RULE_06
	assign ch_a.enable = store_reg[spd_pkg::SPD_BIT_ENABLE_A]; // RULE_07
	assign ch_b.phase = store_reg[spd_pkg::SPD_BIT_PHASE_B]; // RULE_06
	assign ch_b.enable = store_reg[spd_pkg::SPD_BIT_ENABLE_B]; // RULE_07
	assign ch_a.run = run;
	assign ch_b.run = run;
	// One ratio feeds both channels
	assign ch_a.full_scale = full_scale_reg;
	assign ch_b.full_scale = full_scale_reg;
	assign ch_a.ratio = ratio; // RULE_10
	assign ch_b.ratio = ratio; // RULE_10

	spd_channel u_chan_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ch(ch_a)
	);

	spd_channel u_chan_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ch(ch_b)
	);

	assign out_a_pos_o = ch_a.pos;
	assign out_a_pos_oe_o = ch_a.pos_oe;
	assign out_a_neg_o = ch_a.neg;
	assign out_a_neg_oe_o = ch_a.neg_oe;
	assign target_a_o = ch_a.target;
	assign out_b_pos_o = ch_b.pos;
	assign out_b_pos_oe_o = ch_b.pos_oe;
	assign out_b_neg_o = ch_b.neg;
	assign out_b_neg_oe_o = ch_b.neg_oe;
	assign target_b_o = ch_b.target;

	// ----------------------------------------------------------------
	// Read mux and acknowledge
	// ----------------------------------------------------------------
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[spd_pkg::SPD_ST_STORE_LSB +: 8] = store_reg;
		status_word[spd_pkg::SPD_ST_STANDBY] = standby_n_i;
		status_word[spd_pkg::SPD_ST_SUPPLY] = motor_supply_ok_i;
		status_word[spd_pkg::SPD_ST_RUN] = run;
		status_word[spd_pkg::SPD_ST_ACT_A] = ch_a.active;
		status_word[spd_pkg::SPD_ST_ACT_B] = ch_b.active;
		target_word = 32'h0000_0000;
		target_word[spd_pkg::SPD_TGT_A_LSB +: 8] = ch_a.target;
		target_word[spd_pkg::SPD_TGT_B_LSB +: 8] = ch_b.target;
	end

	// Unmapped addresses read zero; the latch word reads zero too
	assign rdata_next = hit_fs ? {24'h000000, full_scale_reg}
		: hit_status ? status_word
		: hit_target ? target_word
		: hit_chop ? {16'h0000, chop_div_reg}
		: 32'h0000_0000;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= req & ~ack_reg;
			if (req & ~ack_reg)
				rdata_reg <= rdata_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

endmodule : spd_top

/* tb/spd_winding_model.sv */
module spd_winding_model (
	// Bridge terminals
	input wire logic pos_i,
	input wire logic pos_oe_i,
	input wire logic neg_i,
	input wire logic neg_oe_i,
	// Winding current sign: 1 plus, 3 minus, 0 none
	output logic [1:0] cur_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A floating terminal carries no current
	always_comb
	begin
		cur_o = 2'h0;
		if (pos_oe_i && neg_oe_i && (pos_i != neg_i))
			cur_o = pos_i ? 2'h1 : 2'h3;
	end
endmodule : spd_winding_model

/* tb/spd_top_chk.sv */
module spd_top_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched ports
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic standby_n_i,
	input wire logic motor_supply_ok_i,
	input wire logic chopper_oscillator_run_o,
	input wire logic chopper_oscillator_tick_o,
	input wire logic out_a_pos_o,
	input wire logic out_a_pos_oe_o,
	input wire logic out_a_neg_o,
	input wire logic out_b_pos_oe_o,
	input wire logic [7:0] target_a_o,
	input wire logic [7:0] target_b_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("no ack");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_drive_sense: assert property (
		out_a_pos_oe_o |-> out_a_pos_o != out_a_neg_o) else $error("sense");
	a_off_target: assert property (
		!out_a_pos_oe_o |-> target_a_o == 8'h00) else $error("target");
	a_run_gate: assert property (
		chopper_oscillator_run_o == (standby_n_i && motor_supply_ok_i))
		else $error("run");
	a_standby_off: assert property (
		!standby_n_i |=> !out_a_pos_oe_o && !out_b_pos_oe_o)
		else $error("standby");
	a_supply_off: assert property (
		!motor_supply_ok_i |=> target_a_o == 8'h00 && target_b_o == 8'h00)
		else $error("supply");
	a_tick_halt: assert property (
		!chopper_oscillator_run_o |=> !chopper_oscillator_tick_o)
		else $error("tick");
	a_targets_same: assert property (
		out_a_pos_oe_o && out_b_pos_oe_o |-> target_a_o == target_b_o)
		else $error("ratio");
endmodule : spd_top_chk

bind spd_top spd_top_chk u_chk (.*);

/* tb/spd_top_test.sv */
module spd_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic latch_strobe_i, standby_n_i, motor_supply_ok_i;
	logic chopper_oscillator_run_o, chopper_oscillator_tick_o;
	logic [7:0] wb_adr_i, shift_word_i, target_a_o, target_b_o;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd, e;
	logic out_a_pos_o, out_a_pos_oe_o, out_a_neg_o, out_a_neg_oe_o;
	logic out_b_pos_o, out_b_pos_oe_o, out_b_neg_o, out_b_neg_oe_o;
	logic [1:0] cur_a, cur_b;
	int miscompares = 0, checked = 0, cycles = 0;
	// Four-state so an unknown tick is not counted as zero
	logic [31:0] ticks;
	logic [6:0] pct [16] = '{7'h00, 7'h05, 7'h0a, 7'h0f, 7'h19, 7'h1d,
		7'h26, 7'h2b, 7'h34, 7'h3c, 7'h43, 7'h4a, 7'h50, 7'h56, 7'h5e, 7'h64};
	// Full step, then half step; off channels get odd polarity on purpose
	logic [3:0] seq [12] = '{4'hf, 4'h7, 4'h5, 4'hd, 4'hf, 4'hb,
		4'h7, 4'h6, 4'h5, 4'h9, 4'hd, 4'he};

	spd_top DUT (.*);
	spd_winding_model u_wa (.pos_i(out_a_pos_o), .pos_oe_i(out_a_pos_oe_o),
		.neg_i(out_a_neg_o), .neg_oe_i(out_a_neg_oe_o), .cur_o(cur_a));
	spd_winding_model u_wb (.pos_i(out_b_pos_o), .pos_oe_i(out_b_pos_oe_o),
		.neg_i(out_b_neg_o), .neg_oe_i(out_b_neg_oe_o), .cur_o(cur_b));

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			report_and_stop;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task latch(input logic [7:0] w);
		@(posedge clk_i);
		shift_word_i <= w;
		latch_strobe_i <= 1'b1;
		@(posedge clk_i);
		latch_strobe_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : latch

	task settle;
		repeat (3) @(posedge clk_i);
	endtask : settle

	task count_ticks;
		ticks = 0;
		repeat (20)
		begin
			@(posedge clk_i);
			ticks += chopper_oscillator_tick_o;
		end
	endtask : count_ticks

	function automatic logic [1:0] cur_of(input logic p, input logic en);
		return en ? (p ? 2'h1 : 2'h3) : 2'h0;
	endfunction : cur_of

	initial
	begin
		{wb_cyc_i, wb_stb_i, wb_we_i, latch_strobe_i} = 4'h0;
		{wb_adr_i, shift_word_i, wb_dat_i} = '0;
		wb_sel_i = 4'hf;
		{standby_n_i, motor_supply_ok_i, rst_i} = 3'h7;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'hff);
		wb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, 8'h00, 32'hc8);
		for (int i = 0; i < 16; i++)
		begin
			latch({4'hf, i[3:0]});
			e = 8'hc8 * pct[i] / 8'h64;
			chk(target_a_o, e);
			wb(1'b0, 8'h0c, 32'h0);
			chk(rd, {16'h0, e[7:0], e[7:0]});
		end
		for (int k = 0; k < 12; k++)
		begin
			latch({seq[k], 4'hf});
			chk(cur_a, cur_of(seq[k][3], seq[k][2]));
			chk(cur_b, cur_of(seq[k][1], seq[k][0]));
		end
		@(posedge clk_i);
		shift_word_i <= 8'h3f;
		latch_strobe_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		shift_word_i <= 8'hc0;
		settle;
		wb(1'b0, 8'h08, 32'h0);
		chk(rd[7:0], 8'h3f);
		latch_strobe_i <= 1'b0;
		wb(1'b1, 8'h04, 32'h1);
		settle;
		chk({out_a_pos_oe_o, out_b_pos_oe_o, target_b_o}, 10'h200);
		latch(8'hff);
		standby_n_i <= 1'b0;
		wb(1'b1, 8'h10, 32'h3);
		settle;
		chk({cur_a, cur_b, target_b_o}, 12'h0);
		count_ticks;
		chk(ticks, 0);
		wb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h3);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd[12:8], 5'h02);
		standby_n_i <= 1'b1;
		motor_supply_ok_i <= 1'b0;
		settle;
		chk({cur_a, target_a_o}, 10'h0);
		motor_supply_ok_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		count_ticks;
		chk(ticks, 5);
		chk({cur_a, cur_b, target_a_o}, 12'h5c8);
		// Reset in mid-run restores full scale and floats both channels
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'hff);
		chk({out_a_pos_oe_o, out_b_pos_oe_o, target_a_o}, 10'h0);
		report_and_stop;
	end
endmodule : spd_top_test
